//--- rtl/ldcfg_pkg.sv
// package: register map, field layout and reset values of the led config block
`default_nettype none
package ldcfg_pkg;
  localparam logic [7:0] ADDR_ENABLE   = 8'h00;
  localparam logic [7:0] ADDR_RANGE    = 8'h01;
  localparam logic [7:0] ADDR_OUTCFG   = 8'h02;
  localparam logic [7:0] ADDR_APPLY    = 8'h0f;
  localparam logic [7:0] ADDR_FLAGCLR  = 8'h13;
  localparam logic [7:0] ADDR_SCALE0   = 8'h14;
  localparam logic [7:0] ADDR_DUTY0    = 8'h18;
  localparam logic [7:0] ADDR_EVENT    = 8'h40;
  localparam logic [7:0] APPLY_KEY     = 8'h55;
  localparam logic [7:0] RESET_VALUE   = 8'h00;
  localparam int         ENABLE_BIT    = 0;
  localparam int         RANGE_BIT     = 0;
  localparam int         OUTEN_LSB     = 0;
  localparam int         DIMMODE_LSB   = 4;
  localparam int         THERMAL_BIT   = 1;
  localparam int         POWER_BIT     = 0;
  localparam int         NUM_CH        = 3;
  localparam logic [7:0] PWM_LAST_PHASE = 8'hfe;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldcfg_req_type;

  typedef struct packed {
    logic [2:0] out_en;
    logic [2:0] dim_mode;
    logic       range_hi;
  } ldcfg_cfg_type;
endpackage
`default_nettype wire

//--- rtl/ldcfg_pwm.sv
// one pwm generator per channel, gated by enable bits
`default_nettype none
module ldcfg_pwm (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        active,
  input  wire logic [2:0]  ch_en,
  input  wire logic [23:0] duty,
  output logic [2:0]       pwm_out
);
  logic [7:0] phase_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_reg <= 8'h00;
    end else if (clk_en) begin
      phase_reg <= (phase_reg == ldcfg_pkg::PWM_LAST_PHASE) ? 8'h00 : phase_reg + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ldcfg_pkg::NUM_CH; g++) begin : g_ch
      // 0xff compares above every phase 0..0xfe, so full duty is steady on
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pwm_out[g] <= 1'b0;
        end else if (clk_en) begin
          pwm_out[g] <= active && ch_en[g] && (phase_reg < duty[g*8 +: 8]);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/ldcfg_top.sv
// register bank and output stage of the three channel led sink controller
`default_nettype none
module ldcfg_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire ldcfg_pkg::ldcfg_req_type req,
  input  wire logic                  thermal_event,
  input  wire logic                  por_event,
  output logic [7:0]                 rdata,
  output logic                       rvalid,
  output logic                       device_active,
  output ldcfg_pkg::ldcfg_cfg_type   cfg_live,
  output logic [23:0]                scale_live,
  output logic [2:0]                 pwm_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic                     enable_reg;
  ldcfg_pkg::ldcfg_cfg_type cfg_shadow_reg;
  logic [7:0]               duty_reg [3];
  logic                     therm_flag_reg;
  logic                     por_flag_reg;
  logic                     wr_hit_clr;
  logic [23:0]              duty_bus;

  assign wr_hit_clr = req.wr && req.addr == ldcfg_pkg::ADDR_FLAGCLR;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
    end else if (clk_en && req.wr && req.addr == ldcfg_pkg::ADDR_ENABLE) begin
      enable_reg <= req.wdata[ldcfg_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      device_active <= 1'b0;
    end else if (clk_en) begin
      device_active <= enable_reg;
    end
  end

  // shadow copies: the host may edit freely, nothing moves until apply
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_shadow_reg <= '0;
    end else if (clk_en && req.wr) begin
      if (req.addr == ldcfg_pkg::ADDR_RANGE) begin
        cfg_shadow_reg.range_hi <= req.wdata[ldcfg_pkg::RANGE_BIT];
      end
      if (req.addr == ldcfg_pkg::ADDR_OUTCFG) begin
        cfg_shadow_reg.out_en   <= req.wdata[ldcfg_pkg::OUTEN_LSB +: 3];
        cfg_shadow_reg.dim_mode <= req.wdata[ldcfg_pkg::DIMMODE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_live <= '0;
    end else if (clk_en && req.wr && req.addr == ldcfg_pkg::ADDR_APPLY
                 && req.wdata == ldcfg_pkg::APPLY_KEY) begin
      cfg_live <= cfg_shadow_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ldcfg_pkg::NUM_CH; g++) begin : g_ch
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          scale_live[g*8 +: 8] <= ldcfg_pkg::RESET_VALUE;
          duty_reg[g]          <= ldcfg_pkg::RESET_VALUE;
        end else if (clk_en && req.wr) begin
          if (req.addr == ldcfg_pkg::ADDR_SCALE0 + 8'(g)) begin
            scale_live[g*8 +: 8] <= req.wdata;
          end
          if (req.addr == ldcfg_pkg::ADDR_DUTY0 + 8'(g)) begin
            duty_reg[g] <= req.wdata;
          end
        end
      end
      assign duty_bus[g*8 +: 8] = duty_reg[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // event flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      therm_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (thermal_event) begin
        therm_flag_reg <= 1'b1;
      end else if (wr_hit_clr && req.wdata[ldcfg_pkg::THERMAL_BIT]) begin
        therm_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      por_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (por_event) begin
        por_flag_reg <= 1'b1;
      end else if (wr_hit_clr && req.wdata[ldcfg_pkg::POWER_BIT]) begin
        por_flag_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata  <= ldcfg_pkg::RESET_VALUE;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd;
      rdata  <= ldcfg_pkg::RESET_VALUE;
      if (req.rd) begin
        case (req.addr)
          ldcfg_pkg::ADDR_EVENT:   rdata <= {6'h00, therm_flag_reg, por_flag_reg};
          ldcfg_pkg::ADDR_ENABLE:  rdata <= {7'h00, enable_reg};
          ldcfg_pkg::ADDR_RANGE:   rdata <= {7'h00, cfg_shadow_reg.range_hi};
          ldcfg_pkg::ADDR_OUTCFG:  rdata <= {1'b0, cfg_shadow_reg.dim_mode, 1'b0,
                                             cfg_shadow_reg.out_en};
          ldcfg_pkg::ADDR_SCALE0:  rdata <= scale_live[7:0];
          ldcfg_pkg::ADDR_SCALE0 + 8'h01: rdata <= scale_live[15:8];
          ldcfg_pkg::ADDR_SCALE0 + 8'h02: rdata <= scale_live[23:16];
          ldcfg_pkg::ADDR_DUTY0:   rdata <= duty_reg[0];
          ldcfg_pkg::ADDR_DUTY0 + 8'h01:  rdata <= duty_reg[1];
          ldcfg_pkg::ADDR_DUTY0 + 8'h02:  rdata <= duty_reg[2];
          default:                 rdata <= ldcfg_pkg::RESET_VALUE;
        endcase
      end
    end
  end

  ldcfg_pwm u_pwm (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .active  (device_active),
    .ch_en   (cfg_live.out_en),
    .duty    (duty_bus),
    .pwm_out (pwm_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  sequence s_apply;
    clk_en && req.wr && req.addr == ldcfg_pkg::ADDR_APPLY && req.wdata == ldcfg_pkg::APPLY_KEY;
  endsequence

  property p_therm_set;
    @(posedge sys_clk) disable iff (!rst_n) clk_en && thermal_event |=> therm_flag_reg;
  endproperty
  a_therm_set: assert property (p_therm_set) else $error("thermal flag not set");

  property p_por_set;
    @(posedge sys_clk) disable iff (!rst_n) clk_en && por_event |=> por_flag_reg;
  endproperty
  a_por_set: assert property (p_por_set) else $error("power flag not set");

  property p_event_read;
    @(posedge sys_clk) disable iff (!rst_n)
      clk_en && req.rd && req.addr == ldcfg_pkg::ADDR_EVENT
      |=> rvalid && rdata[7:2] == 6'h00;
  endproperty
  a_event_read: assert property (p_event_read) else $error("event read wrong");

  // disable takes two enabled edges to reach the pins: device_active, then pwm stage
  sequence s_disable_seen;
    !enable_reg && clk_en ##1 clk_en;
  endsequence

  property p_inactive;
    @(posedge sys_clk) disable iff (!rst_n) s_disable_seen |=> pwm_out == 3'h0;
  endproperty
  a_inactive: assert property (p_inactive) else $error("outputs on while disabled");

  property p_no_apply_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !(clk_en && req.wr && req.addr == ldcfg_pkg::ADDR_APPLY
        && req.wdata == ldcfg_pkg::APPLY_KEY) |=> $stable(cfg_live);
  endproperty
  a_no_apply_hold: assert property (p_no_apply_hold) else $error("config moved early");

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
      !clk_en |=> $stable(cfg_live) && $stable(scale_live) && $stable(pwm_out)
                  && $stable(device_active) && $stable(rdata) && $stable(rvalid)
                  && $stable(therm_flag_reg) && $stable(por_flag_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_apply_load;
    @(posedge sys_clk) disable iff (!rst_n) s_apply |=> cfg_live == $past(cfg_shadow_reg);
  endproperty
  a_apply_load: assert property (p_apply_load) else $error("apply did not load");

  property p_therm_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      therm_flag_reg && !(wr_hit_clr && req.wdata[ldcfg_pkg::THERMAL_BIT]) |=> therm_flag_reg;
  endproperty
  a_therm_hold: assert property (p_therm_hold) else $error("thermal flag lost");

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      clk_en && wr_hit_clr && req.wdata[ldcfg_pkg::POWER_BIT] && !por_event |=> !por_flag_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("power flag not cleared");

  property p_duty_direct;
    @(posedge sys_clk) disable iff (!rst_n)
      clk_en && req.wr && req.addr == ldcfg_pkg::ADDR_DUTY0 |=> duty_reg[0] == $past(req.wdata);
  endproperty
  a_duty_direct: assert property (p_duty_direct) else $error("duty not direct");
endmodule
`default_nettype wire

//--- tb/ldcfg_host.sv
// host model driving the register request port of the led config block
`default_nettype none
module ldcfg_host #(
  parameter int WAIT_CYCLES = 100
) (
  input  wire logic                    sys_clk,
  output var  ldcfg_pkg::ldcfg_req_type req,
  input  wire logic [7:0]              rdata,
  input  wire logic                    rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // settle time after power up, scaled down to keep the run short
  task automatic boot();
    repeat (WAIT_CYCLES) @(negedge sys_clk);
  endtask
  // released lines show inverted values so a stale address never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    ok = rvalid;
    d = rdata;
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the led config register block
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     clk_en = 1'b1;
  logic                     thermal_event = 1'b0;
  logic                     por_event = 1'b0;
  ldcfg_pkg::ldcfg_req_type req;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic                     device_active;
  ldcfg_pkg::ldcfg_cfg_type cfg_live;
  logic [23:0]              scale_live;
  logic [2:0]               pwm_out;
  int                       num_errors = 0;
  int                       compares = 0;
  always #5 sys_clk = ~sys_clk;
  ldcfg_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .thermal_event(thermal_event), .por_event(por_event), .rdata(rdata),
    .rvalid(rvalid), .device_active(device_active), .cfg_live(cfg_live),
    .scale_live(scale_live), .pwm_out(pwm_out));
  ldcfg_host #(.WAIT_CYCLES(100)) host (.sys_clk(sys_clk), .req(req), .rdata(rdata),
    .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch rvalid expected 1 seen %b", ok);
      wrap_up();
    end
    `CHK("read data", e, d)
  endtask
  task automatic pulse(input logic th);
    if (th)
      thermal_event <= 1'b1;
    else
      por_event <= 1'b1;
    @(negedge sys_clk);
    thermal_event <= 1'b0;
    por_event <= 1'b0;
    @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h00);
    rd_chk(8'h41, 8'h00);
    `CHK("device_active", 1'b0, device_active)
    `CHK("cfg_live", 7'h00, cfg_live)
  endtask
  task automatic t_flags();
    pulse(1'b0);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h01);
    pulse(1'b1);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h03);
    host.wr(ldcfg_pkg::ADDR_EVENT, 8'h00);
    host.wr(ldcfg_pkg::ADDR_FLAGCLR, 8'h00);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h03);
    host.wr(ldcfg_pkg::ADDR_FLAGCLR, 8'h02);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h01);
    host.wr(ldcfg_pkg::ADDR_FLAGCLR, 8'h01);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h00);
    // event and clear in one cycle: the event must win
    fork
      pulse(1'b1);
      host.wr(ldcfg_pkg::ADDR_FLAGCLR, 8'h02);
    join
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h02);
    host.wr(ldcfg_pkg::ADDR_FLAGCLR, 8'h02);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h00);
  endtask
  // host order: enable, range, scale, config, apply
  task automatic t_program();
    host.wr(ldcfg_pkg::ADDR_ENABLE, 8'h01);
    @(negedge sys_clk);
    `CHK("device_active", 1'b1, device_active)
    host.wr(ldcfg_pkg::ADDR_RANGE, 8'h01);
    host.wr(8'h14, 8'hff);
    host.wr(8'h15, 8'hcc);
    host.wr(8'h16, 8'hcc);
    `CHK("scale_live", 24'hccccff, scale_live)
    host.wr(ldcfg_pkg::ADDR_OUTCFG, 8'h57);
    host.wr(ldcfg_pkg::ADDR_APPLY, 8'h54);
    `CHK("cfg_live held", 7'h00, cfg_live)
    host.wr(ldcfg_pkg::ADDR_APPLY, 8'h55);
    `CHK("cfg_live", 7'h7b, cfg_live)
    rd_chk(ldcfg_pkg::ADDR_OUTCFG, 8'h57);
  endtask
  // duty goes in last, straight to the outputs without a further apply
  // one full pwm period of high samples per channel, after the pipeline settles
  task automatic count_hi(output int hi [3]);
    hi = '{0, 0, 0};
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 255; i++) begin
      @(negedge sys_clk);
      for (int c = 0; c < 3; c++)
        hi[c] += (pwm_out[c] === 1'b1);
    end
  endtask
  task automatic t_duty();
    int hi [3];
    host.wr(8'h18, 8'hff);
    host.wr(8'h19, 8'hcc);
    host.wr(8'h1a, 8'h66);
    count_hi(hi);
    `CHK("duty ch0", 255, hi[0])
    `CHK("duty ch1", 204, hi[1])
    `CHK("duty ch2", 102, hi[2])
  endtask
  // device disable gates all sinks; channel enables move only on apply
  task automatic t_gate();
    int hi [3];
    host.wr(ldcfg_pkg::ADDR_ENABLE, 8'h00);
    count_hi(hi);
    `CHK("off ch0", 0, hi[0])
    `CHK("off ch2", 0, hi[2])
    host.wr(ldcfg_pkg::ADDR_ENABLE, 8'h01);
    host.wr(ldcfg_pkg::ADDR_OUTCFG, 8'h05);
    count_hi(hi);
    `CHK("held ch1", 204, hi[1])
    host.wr(ldcfg_pkg::ADDR_APPLY, 8'h55);
    `CHK("cfg_live", 7'h51, cfg_live)
    count_hi(hi);
    `CHK("gated ch1", 0, hi[1])
    `CHK("open ch2", 102, hi[2])
  endtask
  // with the enable low a write and an event must both be dropped
  task automatic t_freeze();
    logic [2:0] p0;
    int         moved;
    moved = 0;
    p0 = pwm_out;
    clk_en <= 1'b0;
    host.wr(8'h18, 8'h00);
    pulse(1'b1);
    for (int i = 0; i < 255; i++) begin
      @(negedge sys_clk);
      moved += (pwm_out !== p0);
    end
    clk_en <= 1'b1;
    `CHK("frozen pwm", 0, moved)
    rd_chk(8'h18, 8'hff);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h00);
  endtask
  // reset in mid run must bring flags and applied state back to zero
  task automatic t_rerun();
    pulse(1'b1);
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h02);
    rst_n <= 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n <= 1'b1;
    `CHK("cfg_live", 7'h00, cfg_live)
    `CHK("scale_live", 24'h000000, scale_live)
    `CHK("device_active", 1'b0, device_active)
    `CHK("pwm_out", 3'h0, pwm_out)
    rd_chk(ldcfg_pkg::ADDR_EVENT, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n <= 1'b1;
    host.boot();
    t_reset();
    t_flags();
    t_program();
    t_duty();
    t_gate();
    t_freeze();
    t_rerun();
    wrap_up();
  end
  initial begin
    #200000;
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    wrap_up();
  end
endmodule
`default_nettype wire
